// File: hdl/memory_owner_pkg.sv
// Constants shared by the memory-owner and single-wire error register bank
package memory_owner_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ            = 25_000_000;
  localparam int unsigned SYNC_MIN_BPS      = 2000;
  localparam int unsigned SYNC_LIMIT_BPS    = 25000;
  // Longest bit period still at or above the rate: floor of clocks per bit
  localparam int unsigned SYNC_SLOW_CYCLES  = CLK_HZ / SYNC_MIN_BPS;
  localparam int unsigned SYNC_LIMIT_CYCLES = CLK_HZ / SYNC_LIMIT_BPS;
  localparam int unsigned COUNT_W           = 16;
  localparam logic [COUNT_W-1:0] COUNT_MAX  = 16'hFFFF;
  localparam logic [COUNT_W-1:0] COUNT_ONE  = 16'h0001;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // Bus and register map (word indices, byte address = index * 4)
  // ----------------------------------------------------------------
  localparam int unsigned ADR_W  = 8;
  localparam int unsigned IDX_W  = 6;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 8;
  localparam logic [IDX_W-1:0] IDX_OWNER_CTRL = 6'h0E;
  localparam logic [IDX_W-1:0] IDX_ERR_FLAGS  = 6'h14;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 6'h20;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK   = 6'h21;
  localparam logic [REG_W-1:0]  REG_RESET     = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO     = 32'h00000000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned OWNER_SEL_BIT      = 0;
  localparam int unsigned CORE_RESET_BIT     = 1;
  localparam int unsigned ERR_SYNC_SLOW      = 0;
  localparam int unsigned ERR_SYNC_LIMIT     = 1;
  localparam int unsigned ERR_SYNC_STOP      = 2;
  localparam int unsigned ERR_CMD_STOP_VAL   = 3;
  localparam int unsigned ERR_CMD_STOP_SHORT = 4;
  localparam int unsigned ERR_DAT_STOP_VAL   = 5;
  localparam int unsigned ERR_DAT_STOP_SHORT = 6;
  localparam int unsigned ERR_DAT_OVERDRIVE  = 7;

  // ----------------------------------------------------------------
  // Line levels and bus states
  // ----------------------------------------------------------------
  localparam logic LINE_DOMINANT  = 1'b0;
  localparam logic LINE_RECESSIVE = 1'b1;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_t;

endpackage

// File: hdl/sync_two_flop.sv
// Two-flop synchroniser for one pin level
`timescale 1ns/1ps
module sync_two_flop #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic clkEn,
  input  wire logic pinIn,
  output logic      levelOut
);

  logic stageOne;
  logic next_stageOne;
  logic next_levelOut;

  always_comb begin
    next_stageOne = pinIn;
    next_levelOut = stageOne;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stageOne <= RESET_LEVEL;
      levelOut <= RESET_LEVEL;
    end else if (clkEn) begin
      stageOne <= next_stageOne;
      levelOut <= next_levelOut;
    end
  end

endmodule

// File: hdl/sticky_bits.sv
// Sticky flag vector: hardware set wins over any software write
`timescale 1ns/1ps
module sticky_bits #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic         clkEn,
  input  wire logic [W-1:0] setBits,
  input  wire logic         wrEn,
  input  wire logic [W-1:0] wrVal,
  output logic      [W-1:0] flags
);

  logic [W-1:0] next_flags;

  always_comb begin
    next_flags = setBits | (wrEn ? wrVal : flags);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flags <= '0;
    end else if (clkEn) begin
      flags <= next_flags;
    end
  end

endmodule

// File: hdl/memory_owner_regs.sv
// Memory-owner control and single-wire error flag registers on classic Wishbone
//
// Summary of operation
// R1: Owner bit clear gives memories to core; set gives them to external interface.
// R2: Core held in reset while control bit one is set; clearing only releases it.
// R3: Error bit 0 sets when sync-field bit rate is below 2000 bit/s.
// R4: Error bit 1 sets when sync-field rate is below 25 kbit/s, as printed.
// R5: Error bit 2 sets when the sync-field stop bit is too short.
// R6: Error bit 3 sets when the command stop bit has the wrong level.
// R7: Error bit 4 sets when the command stop bit is too short.
// R8: Error bit 5 sets when a data stop bit has the wrong level.
// R9: Error bit 6 sets when a data stop bit is too short.
// R10: Error bit 7 sets when our recessive data stop bit is overdriven dominant.
// R11: Error flags stick until software writes zero or reset occurs.
// R12: External ownership covers the serial, two-wire and single-wire links alike.
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
module memory_owner_regs #(
  parameter logic [15:0] SYNC_SLOW_CYCLES = 16'(memory_owner_pkg::SYNC_SLOW_CYCLES)
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        clkEn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        syncBitActive,
  input  wire logic        stopShortSync,
  input  wire logic        stopValueCmd,
  input  wire logic        stopShortCmd,
  input  wire logic        stopValueData,
  input  wire logic        stopShortData,
  input  wire logic        stopTxRecessive,
  input  wire logic        lineIn,
  output logic             memOwnerExt,
  output logic             coreReset,
  output logic             irq
);

  localparam logic [15:0] SYNC_LIMIT_CYCLES = 16'(memory_owner_pkg::SYNC_LIMIT_CYCLES);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  memory_owner_pkg::bus_state_t busState;
  memory_owner_pkg::bus_state_t next_busState;
  logic                         next_ack;
  logic [31:0]                  next_rdData;
  logic [31:0]                  readMux;
  logic [5:0]                   regIdx;
  logic                         busReq;
  logic                         wrStrobe;
  logic                         wrCtrl;
  logic                         wrErr;
  logic                         wrStatus;
  logic                         wrMask;
  logic [7:0]                   ownerCtrl;
  logic [7:0]                   next_ownerCtrl;
  logic [7:0]                   irqMask;
  logic [7:0]                   next_irqMask;
  logic                         next_irq;
  logic [7:0]                   errFlags;
  logic [7:0]                   irqStatus;
  logic [7:0]                   errSet;
  logic [15:0]                  syncCount;
  logic [15:0]                  next_syncCount;
  logic                         syncActivePrev;
  logic                         next_syncActivePrev;
  logic                         syncEnd;
  logic                         lineSync;

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // Write commits on the edge where the master sees ack, never earlier
  assign regIdx   = wb_adr_i[7:2];
  assign busReq   = wb_cyc_i & wb_stb_i;
  assign wrStrobe = busReq & wb_we_i & wb_sel_i[0] & (busState == memory_owner_pkg::BUS_ACK);
  assign wrCtrl   = wrStrobe & (regIdx == memory_owner_pkg::IDX_OWNER_CTRL);
  assign wrErr    = wrStrobe & (regIdx == memory_owner_pkg::IDX_ERR_FLAGS);
  assign wrStatus = wrStrobe & (regIdx == memory_owner_pkg::IDX_IRQ_STATUS);
  assign wrMask   = wrStrobe & (regIdx == memory_owner_pkg::IDX_IRQ_MASK);

  always_comb begin
    readMux = memory_owner_pkg::DATA_ZERO;
    case (regIdx)
      memory_owner_pkg::IDX_OWNER_CTRL: readMux[7:0] = ownerCtrl;
      memory_owner_pkg::IDX_ERR_FLAGS:  readMux[7:0] = errFlags;
      memory_owner_pkg::IDX_IRQ_STATUS: readMux[7:0] = irqStatus;
      memory_owner_pkg::IDX_IRQ_MASK:   readMux[7:0] = irqMask;
      default:                          readMux      = memory_owner_pkg::DATA_ZERO;
    endcase
  end

  always_comb begin
    next_busState = busState;
    next_ack      = 1'b0;
    next_rdData   = wb_dat_o;
    case (busState)
      memory_owner_pkg::BUS_IDLE: begin
        if (busReq) begin
          next_busState = memory_owner_pkg::BUS_ACK;
          next_ack      = 1'b1;
          next_rdData   = readMux;
        end
      end
      memory_owner_pkg::BUS_ACK: begin
        next_busState = memory_owner_pkg::BUS_IDLE;
        next_ack      = 1'b0;
      end
      default: begin
        next_busState = memory_owner_pkg::BUS_IDLE;
        next_ack      = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      busState <= memory_owner_pkg::BUS_IDLE;
      wb_ack_o <= 1'b0;
      wb_dat_o <= memory_owner_pkg::DATA_ZERO;
    end else if (clkEn) begin
      busState <= next_busState;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_rdData;
    end
  end

  // ----------------------------------------------------------------
  // Owner control and interrupt mask
  // ----------------------------------------------------------------
  always_comb begin
    next_ownerCtrl = wrCtrl ? wb_dat_i[7:0] : ownerCtrl; // R1 R2
    next_irqMask   = wrMask ? wb_dat_i[7:0] : irqMask;
    next_irq       = |(irqStatus & irqMask);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ownerCtrl <= memory_owner_pkg::REG_RESET;
      irqMask   <= memory_owner_pkg::REG_RESET;
      irq       <= 1'b0;
    end else if (clkEn) begin
      ownerCtrl <= next_ownerCtrl;
      irqMask   <= next_irqMask;
      irq       <= next_irq;
    end
  end

  // One select steers every external link, so any of them may program memory
  assign memOwnerExt = ownerCtrl[memory_owner_pkg::OWNER_SEL_BIT]; // R1 R12
  assign coreReset   = ownerCtrl[memory_owner_pkg::CORE_RESET_BIT]; // R2

  // ----------------------------------------------------------------
  // Sync-field bit timing
  // ----------------------------------------------------------------
  // Saturates so a stuck line still reads as the slowest rate
  always_comb begin
    next_syncActivePrev = syncBitActive;
    if (syncBitActive) begin
      next_syncCount = (syncCount == memory_owner_pkg::COUNT_MAX) ? syncCount
                     : syncCount + memory_owner_pkg::COUNT_ONE;
    end else begin
      next_syncCount = memory_owner_pkg::COUNT_ZERO;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      syncCount      <= memory_owner_pkg::COUNT_ZERO;
      syncActivePrev <= 1'b0;
    end else if (clkEn) begin
      syncCount      <= next_syncCount;
      syncActivePrev <= next_syncActivePrev;
    end
  end

  assign syncEnd = syncActivePrev & ~syncBitActive;

  // ----------------------------------------------------------------
  // Line monitor and error events
  // ----------------------------------------------------------------
  sync_two_flop #(
    .RESET_LEVEL (memory_owner_pkg::LINE_RECESSIVE)
  ) lineSyncInst (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .clkEn    (clkEn),
    .pinIn    (lineIn),
    .levelOut (lineSync)
  );

  always_comb begin
    errSet = memory_owner_pkg::REG_RESET;
    errSet[memory_owner_pkg::ERR_SYNC_SLOW]      = syncEnd & (syncCount > SYNC_SLOW_CYCLES); // R3
    errSet[memory_owner_pkg::ERR_SYNC_LIMIT]     = syncEnd & (syncCount > SYNC_LIMIT_CYCLES); // R4
    errSet[memory_owner_pkg::ERR_SYNC_STOP]      = stopShortSync; // R5
    errSet[memory_owner_pkg::ERR_CMD_STOP_VAL]   = stopValueCmd; // R6
    errSet[memory_owner_pkg::ERR_CMD_STOP_SHORT] = stopShortCmd; // R7
    errSet[memory_owner_pkg::ERR_DAT_STOP_VAL]   = stopValueData; // R8
    errSet[memory_owner_pkg::ERR_DAT_STOP_SHORT] = stopShortData; // R9
    errSet[memory_owner_pkg::ERR_DAT_OVERDRIVE]  =
      stopTxRecessive & (lineSync == memory_owner_pkg::LINE_DOMINANT); // R10
  end

  // Software writes the whole byte; a zero clears, a new event still wins
  sticky_bits #(
    .W (memory_owner_pkg::REG_W)
  ) errFlagInst (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clkEn   (clkEn),
    .setBits (errSet),
    .wrEn    (wrErr),
    .wrVal   (wb_dat_i[7:0]),
    .flags   (errFlags)
  ); // R11

  sticky_bits #(
    .W (memory_owner_pkg::REG_W)
  ) irqStatusInst (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clkEn   (clkEn),
    .setBits (errSet),
    .wrEn    (wrStatus),
    .wrVal   (irqStatus & ~wb_dat_i[7:0]),
    .flags   (irqStatus)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ctrl_write_lands: assert property (@(posedge clk_sys) disable iff (reset) // R1
    (clkEn && wrCtrl) |=> (memOwnerExt == $past(wb_dat_i[memory_owner_pkg::OWNER_SEL_BIT]))
                       && (coreReset == $past(wb_dat_i[memory_owner_pkg::CORE_RESET_BIT])))
    else $error("owner control write not applied");

  a_owner_held: assert property (@(posedge clk_sys) disable iff (reset) // R1
    !(clkEn && wrCtrl) |=> $stable(memOwnerExt))
    else $error("owner select changed without a write");

  a_core_reset_hold: assert property (@(posedge clk_sys) disable iff (reset) // R2
    (coreReset && !(clkEn && wrCtrl)) |=> coreReset)
    else $error("core reset dropped without a write");

  a_slow_sync_flag: assert property (@(posedge clk_sys) disable iff (reset) // R3
    (clkEn && syncEnd && (syncCount > SYNC_SLOW_CYCLES)) |=> errFlags[memory_owner_pkg::ERR_SYNC_SLOW])
    else $error("slow sync rate not flagged");

  a_limit_sync_flag: assert property (@(posedge clk_sys) disable iff (reset) // R4
    (clkEn && syncEnd && (syncCount > SYNC_LIMIT_CYCLES)) |=> errFlags[memory_owner_pkg::ERR_SYNC_LIMIT])
    else $error("sync rate below limit not flagged");

  a_fast_sync_clean: assert property (@(posedge clk_sys) disable iff (reset) // R4
    (clkEn && syncEnd && (syncCount <= SYNC_LIMIT_CYCLES) && !errFlags[memory_owner_pkg::ERR_SYNC_LIMIT] && !wrErr)
    |=> !errFlags[memory_owner_pkg::ERR_SYNC_LIMIT])
    else $error("fast sync falsely flagged");

  a_sync_stop_flag: assert property (@(posedge clk_sys) disable iff (reset) // R5
    (clkEn && stopShortSync) |=> errFlags[memory_owner_pkg::ERR_SYNC_STOP])
    else $error("short sync stop not flagged");

  a_cmd_value_flag: assert property (@(posedge clk_sys) disable iff (reset) // R6
    (clkEn && stopValueCmd) |=> errFlags[memory_owner_pkg::ERR_CMD_STOP_VAL])
    else $error("command stop level not flagged");

  a_cmd_short_flag: assert property (@(posedge clk_sys) disable iff (reset) // R7
    (clkEn && stopShortCmd) |=> errFlags[memory_owner_pkg::ERR_CMD_STOP_SHORT])
    else $error("short command stop not flagged");

  a_data_value_flag: assert property (@(posedge clk_sys) disable iff (reset) // R8
    (clkEn && stopValueData) |=> errFlags[memory_owner_pkg::ERR_DAT_STOP_VAL])
    else $error("data stop level not flagged");

  a_data_short_flag: assert property (@(posedge clk_sys) disable iff (reset) // R9
    (clkEn && stopShortData) |=> errFlags[memory_owner_pkg::ERR_DAT_STOP_SHORT])
    else $error("short data stop not flagged");

  a_overdrive_flag: assert property (@(posedge clk_sys) disable iff (reset) // R10
    (clkEn && stopTxRecessive && !lineSync) |=> errFlags[memory_owner_pkg::ERR_DAT_OVERDRIVE])
    else $error("overdriven stop bit not flagged");

  a_flags_sticky: assert property (@(posedge clk_sys) disable iff (reset) // R11
    !(clkEn && wrErr) |=> ((errFlags & $past(errFlags)) == $past(errFlags)))
    else $error("error flag lost without a write");

  a_ack_single: assert property (@(posedge clk_sys) disable iff (reset)
    (clkEn && wb_ack_o) |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_ack_needs_req: assert property (@(posedge clk_sys) disable iff (reset)
    (clkEn && !busReq && (busState == memory_owner_pkg::BUS_IDLE)) |=> !wb_ack_o)
    else $error("ack given without a request");

  a_irq_follows: assert property (@(posedge clk_sys) disable iff (reset)
    (clkEn && |(irqStatus & irqMask)) |=> irq)
    else $error("unmasked status did not raise irq");

  a_irq_quiet: assert property (@(posedge clk_sys) disable iff (reset)
    (clkEn && !(|(irqStatus & irqMask))) |=> !irq)
    else $error("irq raised with no unmasked status");

endmodule

// File: dv/single_wire_host_model.sv
// Far-side link model: sync bits, stop-bit faults and line overdrive
`timescale 1ns/1ps
module single_wire_host_model (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        go,
  input  wire logic [2:0]  kind,
  input  wire logic [15:0] len,
  output logic             busy,
  output logic             syncBitActive,
  output logic             stopShortSync,
  output logic             stopValueCmd,
  output logic             stopShortCmd,
  output logic             stopValueData,
  output logic             stopShortData,
  output logic             stopTxRecessive,
  output logic             lineIn
);
  logic [15:0] count;
  logic [2:0]  held;
  logic [15:0] next_count;
  logic [2:0]  next_held;

  always_comb begin
    next_count = count;
    next_held = held;
    if (go && count == 16'h0000) begin
      next_count = len;
      next_held = kind;
    end else if (count != 16'h0000) begin
      next_count = count - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      count <= 16'h0000;
      held <= 3'h0;
    end else begin
      count <= next_count;
      held <= next_held;
    end
  end

  // Any serial link may act as the external owner
  assign busy = count != 16'h0000;
  assign syncBitActive = busy && held == 3'h0;
  assign stopShortSync = busy && held == 3'h1;
  assign stopValueCmd = busy && held == 3'h2;
  assign stopShortCmd = busy && held == 3'h3;
  assign stopValueData = busy && held == 3'h4;
  assign stopShortData = busy && held == 3'h5;
  assign stopTxRecessive = busy && held[2] && held[1];
  // Pull-up brings a released line back to recessive
  assign lineIn = !(busy && held == 3'h6);
endmodule

// File: dv/test_memory_owner_regs.sv
// Self-checking bench for the memory-owner and link error register bank
`timescale 1ns/1ps
module test_memory_owner_regs;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  // Short slow limit keeps runs brief; still above the fixed 1000
  localparam logic [15:0] SLOW = 16'h04B0;
  logic        clk_sys, reset, clkEn, go, busy, irq;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i, v;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, d, seed;
  logic [2:0]  kind;
  logic [15:0] len;
  logic        sBA, sSS, sVC, sSC, sVD, sSD, sTR, line, own, coreRst;
  int          num_errors, samples_checked;

  memory_owner_regs #(.SYNC_SLOW_CYCLES(SLOW)) dut_u (.clk_sys(clk_sys), .reset(reset), .clkEn(clkEn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .syncBitActive(sBA), .stopShortSync(sSS),
    .stopValueCmd(sVC), .stopShortCmd(sSC), .stopValueData(sVD), .stopShortData(sSD),
    .stopTxRecessive(sTR), .lineIn(line), .memOwnerExt(own), .coreReset(coreRst), .irq(irq));
  single_wire_host_model far_u (.clk_sys(clk_sys), .reset(reset), .go(go), .kind(kind), .len(len),
    .busy(busy), .syncBitActive(sBA), .stopShortSync(sSS), .stopValueCmd(sVC), .stopShortCmd(sSC),
    .stopValueData(sVD), .stopShortData(sSD), .stopTxRecessive(sTR), .lineIn(line));

  always #20 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Holds the request until ack is sampled high, then releases it
  task automatic wbCycle(input logic we, input logic [7:0] adr, input logic [7:0] dat, input logic [3:0] sel,
                         output logic [31:0] rdat);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= {24'h000000, dat};
    // No fixed wait count; only the watchdog ends a lost answer
    do begin
      @(posedge clk_sys);
    end while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wrReg(input logic [7:0] adr, input logic [7:0] dat);
    logic [31:0] r;
    wbCycle(1'b1, adr, dat, 4'h1, r);
  endtask

  task automatic expectReg(input logic [7:0] adr, input logic [7:0] exp);
    logic [31:0] r;
    wbCycle(1'b0, adr, 8'h00, 4'hF, r);
    check(r, {24'h000000, exp});
  endtask

  task automatic runLink(input logic [2:0] k, input logic [15:0] l);
    int n;
    n = 0;
    @(posedge clk_sys);
    go <= 1'b1;
    kind <= k;
    len <= l;
    @(posedge clk_sys);
    go <= 1'b0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (busy === 1'b1 && n < 1400);
    repeat (3) @(posedge clk_sys);
  endtask

  function automatic logic [7:0] linkExp(input logic [2:0] k, input logic [15:0] l);
    if (k == 3'h0) return {6'h00, l > 16'h03E8, l > SLOW};
    if (k == 3'h7) return 8'h00;
    return 8'h01 << (k + 3'h1);
  endfunction

  task automatic linkCase(input logic [2:0] k, input logic [15:0] l);
    wrReg(8'h50, 8'h00);
    runLink(k, l);
    expectReg(8'h50, linkExp(k, l));
    repeat (10) @(posedge clk_sys);
    expectReg(8'h50, linkExp(k, l));
    wrReg(8'h50, 8'h00);
    expectReg(8'h50, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    reset = 1'b1;
    clkEn = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, go} = 4'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i, kind, len} = 63'h0;
    seed = $urandom(32'hB4F9);
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    expectReg(8'h38, 8'h00);
    expectReg(8'h50, 8'h00);
    check({30'h0, own, coreRst}, 32'h0);
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 8'hFF : 8'($urandom());
      wrReg(8'h38, v);
      expectReg(8'h38, v);
      check({30'h0, own, coreRst}, {30'h0, v[0], v[1]});
    end
    wbCycle(1'b1, 8'h38, ~v, 4'hE, d);
    wrReg(8'h3C, ~v);
    expectReg(8'h38, v);
    expectReg(8'h3C, 8'h00);
    wrReg(8'h38, 8'h00);
    @(posedge clk_sys);
    check({30'h0, own, coreRst}, 32'h0);
    wrReg(8'h50, 8'h5A);
    expectReg(8'h50, 8'h5A);
    linkCase(3'h0, 16'h03E8);
    linkCase(3'h0, 16'h03E9);
    linkCase(3'h0, SLOW);
    linkCase(3'h0, SLOW + 16'h0001);
    for (int i = 0; i < 3; i++) linkCase(3'h0, 16'h0384 + 16'($urandom_range(400)));
    for (int k = 1; k < 8; k++) linkCase(3'(k), (k > 5) ? 16'h0008 : 16'h0001);
    // Clock enable low: a link event must leave no trace
    clkEn <= 1'b0;
    runLink(3'h2, 16'h0001);
    clkEn <= 1'b1;
    expectReg(8'h50, 8'h00);
    wrReg(8'h80, 8'hFF);
    wrReg(8'h84, 8'h00);
    runLink(3'h1, 16'h0001);
    check({31'h0, irq}, 32'h0);
    expectReg(8'h80, 8'h04);
    wrReg(8'h84, 8'h04);
    repeat (3) @(posedge clk_sys);
    check({31'h0, irq}, 32'h1);
    wrReg(8'h80, 8'h04);
    repeat (3) @(posedge clk_sys);
    check({31'h0, irq}, 32'h0);
    expectReg(8'h80, 8'h00);
    // Mid-run reset clears owner control, error flags and the irq, owner and core-reset outputs
    wrReg(8'h38, 8'h03);
    wrReg(8'h50, 8'hA5);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    expectReg(8'h38, 8'h00);
    expectReg(8'h50, 8'h00);
    check({29'h0, irq, own, coreRst}, 32'h0);
    stop_test();
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    num_errors++;
    stop_test();
  end
endmodule
